// File: counter_serial_irq.sv
/*
 * Counter/serial interrupt inputs: two 8-bit auto-reload counters and a
 * 9-bit serial receiver whose flags serve as edge-triggered interrupts.
 * Assumes count and receive pins already synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R1) Five vectored sources: two ext, two timers, serial
// (R2) Mode 2: 8-bit counter with auto reload
// (R3) Software loads count and reload with ones
// (R4) Software sets gate, count, mode, run, enables
// (R5) Timer mode value 66 hex for both
// (R6) Falling count edge overflows, raises timer interrupt
// (R7) Overflow reloads counter from reload byte
// (R8) Software may set priorities per source
// (R9) Serial mode 2: 9-bit oscillator-clocked receiver
// (R10) Reception starts on receive pin falling edge
// (R11) Start valid only if low five-eighths bit
// (R12) Source holds receive low one to nine bits
// (R13) Serial control register set to 90 hex
// (R14) Software treats serial interrupt as external
// (R15) Software ignores the received byte
// (R16) Receive flag set after eighth data bit
// (R17) Service routine clears receive flag
// (R18) Timer flag clears on vector to routine
module counter_serial_irq (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire ext_irq_pkg::tmr_cfg_t [1:0] tmr_cfg,
    input  wire logic [1:0]                  count_load,
    input  wire logic [7:0]                  load_value,
    input  wire logic [7:0]                  reload_value,
    input  wire logic [1:0]                  timer_irq_enable,
    input  wire logic                        serial_irq_enable,
    input  wire logic                        global_irq_enable,
    input  wire logic [1:0]                  ext_irq_in,
    input  wire logic [1:0]                  timer_vector_ack,
    input  wire ext_irq_pkg::ser_cfg_t       ser_cfg,
    input  wire logic                        receive_flag_clr,
    input  wire logic                        timer0_count_pin,
    input  wire logic                        timer1_count_pin,
    input  wire logic                        rx_pin,
    output logic [7:0]                       timer0_count_byte,
    output logic [7:0]                       timer1_count_byte,
    output logic [1:0]                       timer_ovf_flag,
    output logic                             receive_irq_flag,
    output logic [7:0]                       rx_byte,
    output logic [4:0]                       irq_request
);

    // ****************************************************************
    // Timer section
    // ****************************************************************
    logic [1:0] pin_now;
    logic [1:0] pin_q;
    logic [7:0] count_q [2];
    logic [7:0] reload_q [2];
    logic [1:0] ovf_q;

    assign pin_now = {timer1_count_pin, timer0_count_pin};

    // Previous pin level, used to find falling edges
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_q <= 2'h3;
        end else begin
            pin_q <= pin_now;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < ext_irq_pkg::N_TMR; gi++) begin : g_tmr
            logic mode2;
            logic tick;
            logic wrap;
            // Only the external-count reload mode is modelled; other modes hold
            assign mode2 = {tmr_cfg[gi].mode_high_bit, tmr_cfg[gi].mode_low_bit}
                           == ext_irq_pkg::TMR_MODE_RELOAD; // R2
            assign tick  = mode2 && tmr_cfg[gi].run && tmr_cfg[gi].ext_count
                           && !tmr_cfg[gi].gate && pin_q[gi] && !pin_now[gi]; // R6
            assign wrap  = tick && (count_q[gi] == ext_irq_pkg::ALL_ONES);

            // Counter advances on a falling edge and reloads on wrap
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    count_q[gi]  <= ext_irq_pkg::BYTE_ZERO;
                    reload_q[gi] <= ext_irq_pkg::BYTE_ZERO;
                end else begin
                    if (count_load[gi]) begin
                        count_q[gi]  <= load_value;
                        reload_q[gi] <= reload_value;
                    end else if (wrap) begin
                        count_q[gi] <= reload_q[gi]; // R7
                    end else if (tick) begin
                        count_q[gi] <= count_q[gi] + 8'h01;
                    end
                end
            end

            // Flag set wins over the vector acknowledge
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    ovf_q[gi] <= 1'b0;
                end else if (wrap) begin
                    ovf_q[gi] <= 1'b1; // R6
                end else if (timer_vector_ack[gi]) begin
                    ovf_q[gi] <= 1'b0; // R18
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Serial receiver, mode 2
    // ****************************************************************
    ext_irq_pkg::rx_state_t state_q;
    ext_irq_pkg::rx_state_t state_d;
    logic [5:0] tick_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic       rx_prev_q;
    logic       ri_q;
    logic       ser_mode2;
    logic       rx_fall;
    logic       bit_end;
    logic       start_ok;
    logic       frame_done;

    assign ser_mode2  = {ser_cfg.mode_select_0, ser_cfg.mode_select_1}
                        == ext_irq_pkg::SER_MODE_2 && ser_cfg.rx_enable; // R9
    assign rx_fall    = ser_mode2 && rx_prev_q && !rx_pin; // R10
    assign bit_end    = tick_q == 6'(ext_irq_pkg::BIT_CLKS - 1);
    // Past the five-eighths point a rising pin no longer aborts the start
    assign start_ok   = tick_q >= 6'(ext_irq_pkg::START_CLKS - 1); // R11
    assign frame_done = (state_q == ext_irq_pkg::RX_DATA) && bit_end
                        && bit_q == 4'(ext_irq_pkg::DATA_BITS - 1); // R16

    // Next state: a glitch shorter than five-eighths bit falls back to idle
    always_comb begin
        state_d = state_q;
        case (state_q)
            ext_irq_pkg::RX_IDLE: begin
                if (rx_fall && !ri_q) begin
                    state_d = ext_irq_pkg::RX_START;
                end
            end
            ext_irq_pkg::RX_START: begin
                if (rx_pin && !start_ok) begin
                    state_d = ext_irq_pkg::RX_IDLE; // R11
                end else if (bit_end) begin
                    state_d = ext_irq_pkg::RX_DATA;
                end
            end
            ext_irq_pkg::RX_DATA: begin
                if (frame_done) begin
                    state_d = ext_irq_pkg::RX_IDLE;
                end
            end
            default: state_d = ext_irq_pkg::RX_IDLE;
        endcase
    end

    // Bit timing and data capture; the 9th bit is ignored, the flag comes early
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q   <= ext_irq_pkg::RX_IDLE;
            tick_q    <= 6'h00;
            bit_q     <= 4'h0;
            shift_q   <= 8'h00;
            rx_prev_q <= 1'b1;
        end else begin
            state_q   <= state_d;
            rx_prev_q <= rx_pin;
            tick_q    <= (state_q == ext_irq_pkg::RX_IDLE || bit_end) ? 6'h00 : tick_q + 6'h01;
            if (state_q == ext_irq_pkg::RX_START) begin
                bit_q <= 4'h0;
            end else if (state_q == ext_irq_pkg::RX_DATA && bit_end) begin
                bit_q   <= bit_q + 4'h1;
                shift_q <= {rx_pin, shift_q[7:1]};
            end
        end
    end

    // Receive flag: a new frame end beats a simultaneous clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ri_q <= 1'b0;
        end else if (frame_done) begin
            ri_q <= 1'b1; // R16
        end else if (receive_flag_clr) begin
            ri_q <= 1'b0; // R17
        end
    end

    // ****************************************************************
    // Outputs, registered
    // ****************************************************************
    logic [4:0] req_d;
    // Order: ext0, timer0, ext1, timer1, serial
    assign req_d = global_irq_enable ? {serial_irq_enable & ri_q,
                                        timer_irq_enable[1] & ovf_q[1],
                                        ext_irq_in[1],
                                        timer_irq_enable[0] & ovf_q[0],
                                        ext_irq_in[0]} : 5'h00; // R1

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer0_count_byte <= 8'h00;
            timer1_count_byte <= 8'h00;
            timer_ovf_flag    <= 2'h0;
            receive_irq_flag  <= 1'b0;
            rx_byte           <= 8'h00;
            irq_request       <= 5'h00;
        end else begin
            timer0_count_byte <= count_q[0];
            timer1_count_byte <= count_q[1];
            timer_ovf_flag    <= ovf_q;
            receive_irq_flag  <= ri_q;
            rx_byte           <= shift_q; // R15
            irq_request       <= req_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    ovf_reload_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
        g_tmr[0].wrap && !count_load[0] |=> count_q[0] == reload_q[0])
        else $error("timer0 did not reload on overflow");
    ovf_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
        g_tmr[1].wrap |=> ovf_q[1] ##1 timer_ovf_flag[1])
        else $error("timer1 overflow flag missing");
    ack_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R18
        timer_vector_ack[0] && !g_tmr[0].wrap |=> !ovf_q[0])
        else $error("timer0 flag not cleared by ack");
    mode_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
        !g_tmr[0].mode2 && !count_load[0] |=> $stable(count_q[0]))
        else $error("timer0 counted outside mode 2");
    start_seen_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
        state_q == ext_irq_pkg::RX_IDLE && rx_fall && !ri_q |=> state_q == ext_irq_pkg::RX_START)
        else $error("receive start not taken");
    glitch_drop_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
        state_q == ext_irq_pkg::RX_START && rx_pin && tick_q < 6'(ext_irq_pkg::START_CLKS - 1)
        |=> state_q == ext_irq_pkg::RX_IDLE)
        else $error("short start pulse accepted");
    ri_timing_a: assert property (@(posedge sys_clk) disable iff (rst) // R16
        $rose(ri_q) |-> $past(state_q) == ext_irq_pkg::RX_DATA && $past(bit_q) == 4'h7)
        else $error("receive flag not after eighth bit");
    ri_sticky_a: assert property (@(posedge sys_clk) disable iff (rst) // R17
        ri_q && !receive_flag_clr |=> ri_q)
        else $error("receive flag dropped without clear");
    req_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
        !global_irq_enable |=> irq_request == 5'h00)
        else $error("request passed with global enable off");
    mode9_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
        !ser_mode2 && state_q == ext_irq_pkg::RX_IDLE |=> state_q == ext_irq_pkg::RX_IDLE)
        else $error("receiver started outside mode 2");

    tmr_irq_c: cover property (@(posedge sys_clk) g_tmr[0].wrap ##2 irq_request[1]);
    ser_irq_c: cover property (@(posedge sys_clk) $rose(ri_q) ##2 irq_request[4]);
    glitch_c:  cover property (@(posedge sys_clk)
        state_q == ext_irq_pkg::RX_START ##1 state_q == ext_irq_pkg::RX_IDLE);

endmodule

`default_nettype wire

// File: ext_irq_pkg.sv
/*
 * Package for the counter/serial interrupt input block: mode encodings,
 * timing counts and the packed structs for timer and serial control bits.
 * Assumes a single 10 MHz core clock.
 */
package ext_irq_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS      = 100;
    // Serial mode 2 bit time is 32 oscillator periods at this clock model
    localparam int BIT_CLKS           = 32;
    localparam int BIT_TIME_NS        = BIT_CLKS * CLK_PERIOD_NS;
    // Least start-low time: five-eighths of a bit, rounded up
    localparam int START_NUM          = 5;
    localparam int START_DEN          = 8;
    localparam int START_CLKS         = (BIT_CLKS * START_NUM + START_DEN - 1) / START_DEN;
    localparam int DATA_BITS          = 8;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    localparam logic [1:0] TMR_MODE_RELOAD = 2'h2;
    localparam logic [1:0] SER_MODE_2      = 2'h2;
    localparam logic [7:0] ALL_ONES        = 8'hFF;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;
    localparam int         N_TMR           = 2;

    // Per-timer configuration bits
    typedef struct packed {
        logic       gate;
        logic       ext_count;
        logic       mode_high_bit;
        logic       mode_low_bit;
        logic       run;
    } tmr_cfg_t;

    // Serial configuration bits
    typedef struct packed {
        logic       mode_select_0;
        logic       mode_select_1;
        logic       multiprocessor_bit;
        logic       rx_enable;
    } ser_cfg_t;

    // Receiver states, one-hot
    typedef enum logic [2:0] {
        RX_IDLE  = 3'h1,
        RX_START = 3'h2,
        RX_DATA  = 3'h4
    } rx_state_t;

endpackage

// File: ext_irq_source.sv
/*
 * Far-side model: external sources that drive the two count pins and
 * the receive pin. Assumes one shared sys_clk; every pin idles high.
 */
`timescale 1ns/1ps
`default_nettype none

module ext_irq_source (
    input  wire logic       sys_clk,
    input  wire logic [1:0] fire_tmr,
    input  wire logic       fire_rx,
    input  wire logic [8:0] rx_low,
    output logic            timer0_count_pin,
    output logic            timer1_count_pin,
    output logic            rx_pin
);
    // ****************************************************************
    // Low-pulse timers
    // ****************************************************************
    logic [1:0] t0_low_q;
    logic [1:0] t1_low_q;
    logic [8:0] rx_low_q;

    // Two-cycle low pulse, so the pin is high again before the next edge
    always @(posedge sys_clk) begin
        t0_low_q <= fire_tmr[0] ? 2'h2 : t0_low_q - {1'b0, t0_low_q != 2'h0};
        t1_low_q <= fire_tmr[1] ? 2'h2 : t1_low_q - {1'b0, t1_low_q != 2'h0};
        // Low for the commanded count of sys_clk cycles, 0 to 511
        rx_low_q <= fire_rx ? rx_low : rx_low_q - {8'h00, rx_low_q != 9'h000};
    end

    initial begin
        t0_low_q = 2'h0;
        t1_low_q = 2'h0;
        rx_low_q = 9'h000;
    end

    // Released pins return to their idle high level
    assign timer0_count_pin = (t0_low_q == 2'h0);
    assign timer1_count_pin = (t1_low_q == 2'h0);
    assign rx_pin           = (rx_low_q == 9'h000);
endmodule

`default_nettype wire

// File: counter_serial_irq_bench.sv
/*
 * Self-checking bench for counter_serial_irq with the source model.
 * Assumes 10 MHz sys_clk and a 32-clock serial bit time.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module counter_serial_irq_bench;
    logic                        sys_clk, rst, serial_irq_enable, global_irq_enable;
    logic                        receive_flag_clr, fire_rx, receive_irq_flag;
    logic                        timer0_count_pin, timer1_count_pin, rx_pin;
    ext_irq_pkg::tmr_cfg_t [1:0] tmr_cfg;
    ext_irq_pkg::ser_cfg_t       ser_cfg;
    logic [1:0]                  count_load, timer_irq_enable, ext_irq_in, timer_vector_ack;
    logic [1:0]                  fire_tmr, timer_ovf_flag;
    logic [7:0]                  load_value, reload_value, cnt0, cnt1, rx_data;
    logic [8:0]                  rx_low;
    logic [4:0]                  irq_request;
    logic [2:0]                  all_flags;
    int                          failures, total_checks;

    assign all_flags = {receive_irq_flag, timer_ovf_flag};

    counter_serial_irq dut (.sys_clk(sys_clk), .rst(rst), .tmr_cfg(tmr_cfg),
        .count_load(count_load), .load_value(load_value), .reload_value(reload_value),
        .timer_irq_enable(timer_irq_enable), .serial_irq_enable(serial_irq_enable),
        .global_irq_enable(global_irq_enable), .ext_irq_in(ext_irq_in),
        .timer_vector_ack(timer_vector_ack), .ser_cfg(ser_cfg),
        .receive_flag_clr(receive_flag_clr), .timer0_count_pin(timer0_count_pin),
        .timer1_count_pin(timer1_count_pin), .rx_pin(rx_pin), .timer0_count_byte(cnt0),
        .timer1_count_byte(cnt1), .timer_ovf_flag(timer_ovf_flag),
        .receive_irq_flag(receive_irq_flag), .rx_byte(rx_data), .irq_request(irq_request));

    ext_irq_source src (.sys_clk(sys_clk), .fire_tmr(fire_tmr), .fire_rx(fire_rx),
        .rx_low(rx_low), .timer0_count_pin(timer0_count_pin),
        .timer1_count_pin(timer1_count_pin), .rx_pin(rx_pin));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task final_report();
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Let edge updates land before sampling
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task wait_flag(input int i, input int lim);
        for (int k = 0; k < lim; k++) begin
            step(1);
            if (all_flags[i] === 1'b1) return;
        end
        failures++;
        final_report();
    endtask

    task fire_timer(input int i);
        @(posedge sys_clk) fire_tmr[i] <= 1'b1;
        @(posedge sys_clk) fire_tmr[i] <= 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Overflow, reload to all ones, vector clear, and a second event
    task t_timer(input int i);
        fire_timer(i);
        wait_flag(i, 8);
        `CHK("count", 8'hFF, (i ? cnt1 : cnt0))
        step(1);
        `CHK("irq", 1'b1, irq_request[1 + 2 * i])
        @(posedge sys_clk) timer_vector_ack[i] <= 1'b1;
        @(posedge sys_clk) timer_vector_ack[i] <= 1'b0;
        step(3);
        `CHK("ovf", 1'b0, timer_ovf_flag[i])
        fire_timer(i);
        wait_flag(i, 8);
        @(posedge sys_clk) timer_vector_ack[i] <= 1'b1;
        @(posedge sys_clk) timer_vector_ack[i] <= 1'b0;
    endtask

    // Mode 3 is not the reload mode, so pin edges must not count
    task t_mode();
        @(posedge sys_clk) tmr_cfg[0] <= 5'h0F;
        fire_timer(0);
        step(6);
        `CHK("mode", 1'b0, timer_ovf_flag[0])
        @(posedge sys_clk) tmr_cfg[0] <= 5'h0D;
    endtask

    // Flag only after start plus eight data bits; low time one and a quarter bits or nine bits
    task t_serial(input logic [8:0] low, input logic [7:0] data);
        @(posedge sys_clk) begin fire_rx <= 1'b1; rx_low <= low; end
        @(posedge sys_clk) fire_rx <= 1'b0;
        step(9 * 32);
        `CHK("early", 1'b0, receive_irq_flag)
        wait_flag(2, 64);
        step(1);
        `CHK("rxirq", 1'b1, irq_request[4])
        `CHK("rxbyte", data, rx_data)
        @(posedge sys_clk) receive_flag_clr <= 1'b1;
        @(posedge sys_clk) receive_flag_clr <= 1'b0;
        step(3);
        `CHK("rxclr", 1'b0, receive_irq_flag)
    endtask

    // A low pulse shorter than five-eighths of a bit is discarded
    task t_glitch();
        @(posedge sys_clk) begin fire_rx <= 1'b1; rx_low <= 9'h00A; end
        @(posedge sys_clk) fire_rx <= 1'b0;
        step(400);
        `CHK("glitch", 1'b0, receive_irq_flag)
    endtask

    // General inputs pass through, gated by the global enable
    task t_ext();
        @(posedge sys_clk) ext_irq_in <= 2'h3;
        step(3);
        `CHK("ext", 5'h05, irq_request & 5'h05)
        @(posedge sys_clk) global_irq_enable <= 1'b0;
        step(3);
        `CHK("gate", 5'h00, irq_request)
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Main sequence
    initial begin
        failures = 0; total_checks = 0; rst = 1'b1;
        tmr_cfg = '0; ser_cfg = '0; count_load = 2'h0; load_value = 8'h00;
        reload_value = 8'h00; timer_irq_enable = 2'h0; serial_irq_enable = 1'b0;
        global_irq_enable = 1'b0; ext_irq_in = 2'h0; timer_vector_ack = 2'h0;
        receive_flag_clr = 1'b0; fire_tmr = 2'h0; fire_rx = 1'b0; rx_low = 9'h000;
        step(10);
        @(posedge sys_clk) rst <= 1'b0;
        step(1);
        `CHK("rstcnt", 8'h00, cnt0)
        `CHK("rstirq", 5'h00, irq_request)
        // Reload mode from pin counts, all-ones preload, enables on
        @(posedge sys_clk) begin
            tmr_cfg <= {2{5'h0D}};
            ser_cfg <= 4'h9;
            count_load <= 2'h3; load_value <= 8'hFF; reload_value <= 8'hFF;
            timer_irq_enable <= 2'h3; serial_irq_enable <= 1'b1; global_irq_enable <= 1'b1;
        end
        @(posedge sys_clk) count_load <= 2'h0;
        step(2);
        t_timer(0);
        t_timer(1);
        t_mode();
        t_serial(9'h028, 8'hFF);
        t_serial(9'h120, 8'h80);
        t_glitch();
        t_ext();
        final_report();
    end
endmodule

`default_nettype wire
